// >>> src/cmc_mode_ctrl.sv
// Operating-mode controller: ship, low power, active battery, charger.
// Assumes comparator and pin inputs are asynchronous levels; host-side
// request and busy inputs come from logic on clk.
// Wake time counts clk cycles, so the clock must run while waking.
`timescale 1ns/10ps

// Operation
// - Ship latches off until input or press
// - Ship entry ignores charge enable level
// - Battery attach without input or press enters ship
// - Ship request deferred while input valid
// - Ship request deferred while button low
// - Press wakes from ship only above highest undervoltage
// - Clearing request with input cancels entry
// - Watchdog expiry keeps request, entry completes
// - In ship only input comparator, button, max undervoltage
// - Low power needs pin, input, button, idle
// - Low power: rail on, I2C, converter off
// - Leave low power on pin or input
// - Overvoltage input with pin low: active
// - Button low with pin low: active
// - Discharge switch on without input, battery ok
// - Overcurrent turns discharge switch off
// - Battery undervoltage turns switch off
// - Input valid: charger mode, converter running
// - Input attach: rail, path, charge rules
// - Battery attach probes button, wake timer
// - Interrupt, I2C, converter, charge gating
module cmc_mode_ctrl
   import cmc_pkg::*;
#(
   parameter int unsigned WAKE_TIME = WAKE_CYCLES
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // Comparators and pins (asynchronous)
   input  wire logic inputAboveUvlo,
   input  wire logic inputAboveOvp,
   input  wire logic inputAboveBatPlusSleep,
   input  wire logic inputAboveDynamicPower,
   input  wire logic batteryAboveUvlo,
   input  wire logic batteryAboveMaxUvlo,
   input  wire logic batteryOvercurrent,
   input  wire logic wake_button_n,
   input  wire logic low_power_select_n,
   input  wire logic chargeEnable_b,
   // Host side (same clock)
   input  wire logic ship_mode_request,
   input  wire logic hostBusy,
   input  wire logic thermEnableBattery,
   // Mode and rail controls
   output logic [2:0] mode,
   output logic       alwaysOnRailEn,
   output logic       systemRailFromInput,
   output logic       batteryDischargeEn,
   output logic       chargeEn,
   output logic       converterEn,
   output logic       i2cEn,
   output logic       interruptEn,
   output logic       thermSenseEn,
   output logic       oscillatorEn,
   output logic       shipPending
);

   // Three-stage synchronisers; change accepted when stages 2 and 3 agree
   localparam int unsigned NIN = 10;
   logic [NIN-1:0] rawIn;
   logic [NIN-1:0] syncA, syncB, syncC, filt, next_filt;
   assign rawIn = {chargeEnable_b, low_power_select_n, wake_button_n,
                   batteryOvercurrent, batteryAboveMaxUvlo,
                   batteryAboveUvlo, inputAboveDynamicPower,
                   inputAboveBatPlusSleep, inputAboveOvp, inputAboveUvlo};

   // Hold the last agreed value while the late stages disagree
   always_comb begin
      for (int i = 0; i < NIN; i++) begin
         next_filt[i] = (syncB[i] == syncC[i]) ? syncC[i] : filt[i];
      end
   end

   // Reset defaults: button and pin idle high, comparators low
   // A low start value would look like a press right after reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         syncA <= 10'h180;
         syncB <= 10'h180;
         syncC <= 10'h180;
         filt  <= 10'h180;
      end else begin
         syncA <= rawIn;
         syncB <= syncA;
         syncC <= syncB;
         filt  <= next_filt;
      end
   end

   // Filtered levels, named by function
   logic inUv, inOvp, inSlp, inDpm, batUv, batMax, batOc, btnN, lpN;
   assign inUv   = filt[0];
   assign inOvp  = filt[1];
   assign inSlp  = filt[2];
   assign inDpm  = filt[3];
   assign batUv  = filt[4];
   assign batMax = filt[5];
   assign batOc  = filt[6];
   assign btnN   = filt[7];
   assign lpN    = filt[8];

   // Supply above its limit with select low is used as battery mode;
   // it is above the undervoltage level too, so must not win priority
   logic      inCharge;
   cmc_mode_t inputMode;
   assign inCharge  = inUv && !(inOvp && !lpN);
   assign inputMode = inCharge ? CMC_CHARGER : CMC_ACTIVE;

   // Mode state, ship request latch, wake timer, overcurrent latch
   cmc_mode_t             state, next_state;
   logic                  pend, next_pend;
   logic                  reqPrev, next_reqPrev;
   logic                  ocLatch, next_ocLatch;
   logic [WAKE_CNT_W-1:0] wakeCnt, next_wakeCnt;
   logic                  held, next_held;
   logic                  wakeDone;

   // Limitation: WAKE_TIME must fit WAKE_CNT_W bits; the counter
   // stops at its last value so a long hold cannot wrap
   assign wakeDone = (wakeCnt >= WAKE_CNT_W'(WAKE_TIME - 1));

   always_comb begin
      next_state   = state;
      next_pend    = pend;
      next_reqPrev = ship_mode_request;
      next_ocLatch = ocLatch;
      next_wakeCnt = wakeCnt;
      next_held    = held;
      // Rising edge of request arms entry; clear while input valid cancels it
      if (ship_mode_request && !reqPrev) begin
         next_pend = 1'b1;
      end else if (!ship_mode_request && inUv) begin
         next_pend = 1'b0;
      end

      // Watchdog expiry has no path here: request stays set
      // Overcurrent latches the switch off until input is valid or ship mode is reached
      if (batOc) begin
         next_ocLatch = 1'b1;
      end else if (inUv || state == CMC_SHIP) begin
         next_ocLatch = 1'b0;
      end
      unique case (state)
         // Always-on rail up only to look at the button
         CMC_PROBE: begin
            if (inUv) begin
               next_state = inputMode;
            end else if (btnN) begin
               next_state = CMC_SHIP;
            end else begin
               next_state   = CMC_WAKE;
               next_wakeCnt = '0;
               next_held    = 1'b0;
            end
         end

         // Latched off; only input comparator, button and max undervoltage watched
         CMC_SHIP: begin
            next_pend = 1'b0;
            if (inUv) begin
               next_state = inputMode;
            end else if (!btnN && batMax) begin
               next_state   = CMC_WAKE;
               next_wakeCnt = '0;
               next_held    = 1'b0;
            end
         end

         // Press must last the wake time and then release, from probe or ship
         // Count while held; mark held once the time is reached
         CMC_WAKE: begin
            if (inUv) begin
               next_state = inputMode;
            end else if (!btnN) begin
               if (!wakeDone) begin
                  next_wakeCnt = wakeCnt + 1'b1;
               end else begin
                  next_held = 1'b1;
               end
            end else if (held || wakeDone) begin
               next_state = CMC_ACTIVE;
            end else begin
               next_state = CMC_SHIP;                    // Short press
            end
         end

         // Battery powered with clocks and bus running
         CMC_ACTIVE: begin
            if (inUv) begin
               next_state = inputMode;
            end else if (pend && btnN) begin
               next_state = CMC_SHIP;
            end else if (!lpN && btnN && !inOvp && !hostBusy) begin
               next_state = CMC_LOWPWR;
            end
         end

         // Quiet state; pin, button or overvoltage returns to active, valid input to charger
         CMC_LOWPWR: begin
            if (inUv) begin
               next_state = inputMode;
            end else if (pend && btnN) begin
               next_state = CMC_SHIP;
            end else if (lpN || !btnN || inOvp) begin
               next_state = CMC_ACTIVE;
            end
         end

         // Input valid; leaves when it goes or turns unusable
         CMC_CHARGER: begin
            if (!inUv) begin
               if (pend && btnN) begin
                  next_state = CMC_SHIP;
               end else begin
                  next_state = CMC_ACTIVE;
               end
            end else if (!inCharge) begin
               next_state = CMC_ACTIVE;
            end
         end
         // Unused codes fall back to the probe state
         default: next_state = CMC_PROBE;
      endcase
   end

   // State registers only; next values come from the process above
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state   <= CMC_PROBE;
         pend    <= 1'b0;
         reqPrev <= 1'b0;
         ocLatch <= 1'b0;
         wakeCnt <= '0;
         held    <= 1'b0;
      end else begin
         state   <= next_state;
         pend    <= next_pend;
         reqPrev <= next_reqPrev;
         ocLatch <= next_ocLatch;
         wakeCnt <= next_wakeCnt;
         held    <= next_held;
      end
   end

   // Output decode, registered so outputs never glitch
   logic inCharger, onBattery, next_rail, next_sys, next_dis, next_chg;
   logic next_conv, next_com, next_therm, next_osc;
   assign inCharger = (state == CMC_CHARGER);
   assign onBattery = (state == CMC_ACTIVE) || (state == CMC_LOWPWR);

   always_comb begin
      // Ship mode leaves everything off
      next_rail  = (state != CMC_SHIP);
      next_sys   = inCharger && inSlp && !inOvp;
      // Switch stays off while the input feeds the system rail
      next_dis   = (inCharger || onBattery) && batUv
                   && !ocLatch && !(inCharger && next_sys);
      // Charge enable only counts in charger mode
      next_chg   = inCharger && !filt[9] && inDpm;
      next_conv  = inCharger || (state == CMC_ACTIVE);
      next_com   = next_conv;
      // Thermistor in battery mode only when the host asks
      next_therm = inCharger ||
                   ((state == CMC_ACTIVE) && thermEnableBattery);
      next_osc   = next_conv || (state == CMC_WAKE);
   end

   // Outputs only register the decode above
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode                <= 3'h0;
         alwaysOnRailEn      <= 1'b0;
         systemRailFromInput <= 1'b0;
         batteryDischargeEn  <= 1'b0;
         chargeEn            <= 1'b0;
         converterEn         <= 1'b0;
         i2cEn               <= 1'b0;
         interruptEn         <= 1'b0;
         thermSenseEn        <= 1'b0;
         oscillatorEn        <= 1'b0;
         shipPending         <= 1'b0;
      end else begin
         mode                <= state;
         alwaysOnRailEn      <= next_rail;
         systemRailFromInput <= next_sys;
         batteryDischargeEn  <= next_dis;
         chargeEn            <= next_chg;
         converterEn         <= next_conv;
         i2cEn               <= next_com;
         interruptEn         <= next_com;
         thermSenseEn        <= next_therm;
         oscillatorEn        <= next_osc;
         shipPending         <= pend;
      end
   end

endmodule

// >>> src/cmc_pkg.sv
// Constants and types for the charger operating-mode controller.
// Assumes a 50 MHz system clock; all analog thresholds arrive as comparators.
package cmc_pkg;
   // Clock rate and wake press time
   localparam int unsigned CLK_HZ        = 50000000;
   localparam int unsigned WAKE_PRESS_MS = 50;
   localparam int unsigned WAKE_CYCLES   = WAKE_PRESS_MS * (CLK_HZ / 1000);
   localparam int unsigned WAKE_CNT_W    = 22;
   // Input synchroniser depth
   localparam int unsigned SYNC_STAGES   = 3;
   // Operating modes, Gray coded along the usual path
   typedef enum logic [2:0] {
      CMC_PROBE   = 3'b000,
      CMC_SHIP    = 3'b001,
      CMC_WAKE    = 3'b011,
      CMC_ACTIVE  = 3'b010,
      CMC_LOWPWR  = 3'b110,
      CMC_CHARGER = 3'b111
   } cmc_mode_t;
endpackage

// >>> test/cmc_host_model.sv
// Host model: ship request bit and a long bus transfer.
// Assumes bench command pulses arrive on clk.
`timescale 1ns/10ps
module cmc_host_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // Bench commands
   input  wire logic setReq,
   input  wire logic clrReq,
   input  wire logic startXfer,
   input  wire logic inputValid,
   // Toward the controller
   output logic      shipReq,
   output logic      busy
);
   logic [4:0] busyCnt;
   logic [4:0] next_busyCnt;
   logic       next_shipReq;
   // Clear only honoured while input valid, as on the real bus
   always_comb begin
      next_shipReq = shipReq;
      next_busyCnt = busyCnt;
      if (setReq)
         next_shipReq = 1'b1;
      else if (clrReq && inputValid)
         next_shipReq = 1'b0;
      if (startXfer)
         next_busyCnt = 5'h1e;
      else if (busyCnt != 5'h00)
         next_busyCnt = busyCnt - 5'h01;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         shipReq <= 1'b0;
         busyCnt <= 5'h00;
      end else begin
         shipReq <= next_shipReq;
         busyCnt <= next_busyCnt;
      end
   end
   assign busy = (busyCnt != 5'h00);
endmodule

// >>> test/cmc_mode_ctrl_properties.sv
// Checker for the charger mode controller, bound onto its ports.
// Assumes async levels settle through the controller in under 12 cycles.
`timescale 1ns/10ps
module cmc_mode_ctrl_properties
   import cmc_pkg::*;
#(
   parameter int unsigned WAKE_TIME = WAKE_CYCLES
) (
   // Clock, reset and inputs
   input wire logic       clk, rst_b, inputAboveUvlo, batteryOvercurrent,
   input wire logic       batteryAboveUvlo, wake_button_n,
   input wire logic       low_power_select_n, inputAboveOvp,
   // Controller outputs
   input wire logic [2:0] mode,
   input wire logic       alwaysOnRailEn, batteryDischargeEn, chargeEn,
   input wire logic       converterEn, i2cEn, interruptEn, oscillatorEn
);
   // One clock domain, all checks idle in reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_shipOff;
      mode == CMC_SHIP ##1 mode == CMC_SHIP |-> !alwaysOnRailEn &&
         !batteryDischargeEn && !i2cEn && !oscillatorEn;
   endproperty
   a_shipOff: assert property (p_shipOff)
      else $error("Ship mode with a rail or clock on");
   property p_lowPwr;
      (mode == CMC_LOWPWR)[*2] |-> alwaysOnRailEn && !i2cEn &&
         !converterEn && !oscillatorEn;
   endproperty
   a_lowPwr: assert property (p_lowPwr)
      else $error("Low power outputs wrong");
   property p_busGate;
      (mode != CMC_CHARGER && mode != CMC_ACTIVE)[*2] |->
         !interruptEn && !i2cEn;
   endproperty
   a_busGate: assert property (p_busGate)
      else $error("Bus or interrupt on outside active modes");
   property p_chargeGate;
      (mode != CMC_CHARGER)[*2] |-> !chargeEn;
   endproperty
   a_chargeGate: assert property (p_chargeGate)
      else $error("Charging outside charger mode");
   property p_inputWins;
      (inputAboveUvlo && (low_power_select_n || !inputAboveOvp))[*8] |->
         ##[0:6] mode == CMC_CHARGER;
   endproperty
   a_inputWins: assert property (p_inputWins)
      else $error("Valid input without charger mode");
   property p_chargerOn;
      (mode == CMC_CHARGER)[*2] |-> converterEn && alwaysOnRailEn;
   endproperty
   a_chargerOn: assert property (p_chargerOn)
      else $error("Charger mode without converter");
   property p_ocpOff;
      batteryOvercurrent[*8] |-> ##[0:4] !batteryDischargeEn;
   endproperty
   a_ocpOff: assert property (p_ocpOff)
      else $error("Switch on during overcurrent");
   property p_uvloOff;
      (!batteryAboveUvlo)[*8] |-> ##[0:4] !batteryDischargeEn;
   endproperty
   a_uvloOff: assert property (p_uvloOff)
      else $error("Switch on with battery low");
   property p_shipHolds;
      (mode == CMC_SHIP && wake_button_n && !inputAboveUvlo)[*6] |=>
         mode == CMC_SHIP;
   endproperty
   a_shipHolds: assert property (p_shipHolds)
      else $error("Ship left without cause");
   property p_lowPwrExit;
      low_power_select_n[*8] |-> ##[0:4] mode != CMC_LOWPWR;
   endproperty
   a_lowPwrExit: assert property (p_lowPwrExit)
      else $error("Low power kept with select high");
   property p_ovpActive;
      (inputAboveUvlo && inputAboveOvp && !low_power_select_n)[*8] |->
         ##[0:6] mode == CMC_ACTIVE;
   endproperty
   a_ovpActive: assert property (p_ovpActive)
      else $error("Faulty input with select low not in active mode");
endmodule
bind cmc_mode_ctrl cmc_mode_ctrl_properties #(.WAKE_TIME(WAKE_TIME)) chk_u (.*);

// >>> test/tb_top.sv
// Testbench for the charger mode controller.
// Assumes a short wake time parameter so presses stay brief.
`timescale 1ns/10ps
module tb_top;
   import cmc_pkg::*;
   logic clk = 0, rst_b = 0, inputAboveUvlo = 0, inputAboveOvp = 0;
   logic inputAboveBatPlusSleep = 0, inputAboveDynamicPower = 0;
   logic batteryAboveUvlo = 1, batteryAboveMaxUvlo = 1;
   logic batteryOvercurrent = 0, wake_button_n = 1, low_power_select_n = 1;
   logic chargeEnable_b = 0, thermEnableBattery = 1, setReq = 0, clrReq = 0;
   logic startXfer = 0, ship_mode_request, hostBusy, alwaysOnRailEn;
   logic systemRailFromInput, batteryDischargeEn, chargeEn, converterEn;
   logic i2cEn, interruptEn, thermSenseEn, oscillatorEn, shipPending;
   logic [2:0] mode;
   int miscompares = 0, comparisons = 0;
   cmc_mode_ctrl #(.WAKE_TIME(16)) dut_u (.*);
   cmc_host_model host_u (.clk(clk), .rst_b(rst_b), .setReq(setReq),
      .clrReq(clrReq), .startXfer(startXfer), .inputValid(inputAboveUvlo),
      .shipReq(ship_mode_request), .busy(hostBusy));
   always #10 clk = ~clk;
   task automatic chk(input logic [2:0] got, input logic [2:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %b expected %b", $time, got, exp);
      end
   endtask
   // Inputs move 1 ns after the edge, never on it
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic waitMode(input cmc_mode_t m);
      for (int i = 0; i < 60 && mode !== m; i++) step(1);
      chk(mode, m);
      if (mode !== m) finish_test(); // Timed out
   endtask
   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      s = 1;
      step(1);
      s = 0;
   endtask
   // Main sequence of scenarios
   initial begin
      step(4);
      chk({alwaysOnRailEn, batteryDischargeEn, oscillatorEn}, 3'b000);
      rst_b = 1;
      waitMode(CMC_SHIP);
      step(2);
      chk({alwaysOnRailEn, batteryDischargeEn, i2cEn}, 3'b000);
      wake_button_n = 0;
      step(30);
      wake_button_n = 1;
      waitMode(CMC_ACTIVE);
      step(12);
      chk({batteryDischargeEn, i2cEn, thermSenseEn}, 3'b111);
      chk({interruptEn, converterEn, oscillatorEn}, 3'h7);
      batteryOvercurrent = 1;
      step(12);
      batteryOvercurrent = 0;
      step(12);
      chk({2'h0, batteryDischargeEn}, 3'h0);
      {inputAboveUvlo, inputAboveBatPlusSleep, inputAboveDynamicPower} = 3'h7;
      waitMode(CMC_CHARGER);
      step(12);
      chk({systemRailFromInput, chargeEn, converterEn}, 3'b111);
      chargeEnable_b = 1;
      pulse(setReq);
      step(12);
      chk({2'h0, chargeEn}, 3'h0);
      chk(mode, CMC_CHARGER);
      chk({2'h0, shipPending}, 3'h1);
      pulse(clrReq);
      step(12);
      chk({2'h0, shipPending}, 3'h0);
      pulse(setReq);
      wake_button_n = 0;
      {inputAboveUvlo, inputAboveBatPlusSleep, inputAboveDynamicPower} = 3'h0;
      step(14);
      chk(mode, CMC_ACTIVE);
      wake_button_n = 1;
      waitMode(CMC_SHIP);
      wake_button_n = 0;
      step(8);
      wake_button_n = 1;
      step(14);
      chk(mode, CMC_SHIP);
      batteryAboveMaxUvlo = 0;
      wake_button_n = 0;
      step(30);
      wake_button_n = 1;
      step(14);
      chk(mode, CMC_SHIP);
      batteryAboveMaxUvlo = 1;
      wake_button_n = 0;
      step(30);
      wake_button_n = 1;
      waitMode(CMC_ACTIVE);
      pulse(startXfer);
      low_power_select_n = 0;
      step(14);
      chk(mode, CMC_ACTIVE);
      waitMode(CMC_LOWPWR);
      step(2);
      chk({alwaysOnRailEn, i2cEn, oscillatorEn}, 3'b100);
      chk({interruptEn, converterEn, chargeEn}, 3'h0);
      wake_button_n = 0;
      waitMode(CMC_ACTIVE);
      wake_button_n = 1;
      waitMode(CMC_LOWPWR);
      {inputAboveUvlo, inputAboveOvp} = 2'h3;
      waitMode(CMC_ACTIVE);
      step(2);
      chk({systemRailFromInput, chargeEn, batteryDischargeEn}, 3'h1);
      {inputAboveUvlo, inputAboveOvp} = 2'h0;
      waitMode(CMC_LOWPWR);
      low_power_select_n = 1;
      waitMode(CMC_ACTIVE);
      batteryAboveUvlo = 0;
      step(14);
      chk({2'h0, batteryDischargeEn}, 3'h0);
      // Second reset, select low, button held through power-up
      batteryAboveUvlo = 1;
      wake_button_n = 0;
      low_power_select_n = 0;
      rst_b = 0;
      step(4);
      chk(mode, CMC_PROBE);
      rst_b = 1;
      step(30);
      chk(mode, CMC_WAKE);
      wake_button_n = 1;
      waitMode(CMC_ACTIVE);
      waitMode(CMC_LOWPWR);
      finish_test();
   end
endmodule
